/* File: inc/bei_pkg.sv */
// shared constants for the bus interface error handler
package bei_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// error bit positions in both logs and both masks
	localparam int NUM_ERR        = 20;
	localparam int E_ADDR_PAR     = 0;
	localparam int E_CTRL_PAR     = 1;
	localparam int E_ILL_ADTYPE   = 2;
	localparam int E_L2_FLOW_TO   = 3;
	localparam int E_ARB_TO       = 4;
	localparam int E_REP_FATAL4   = 5;
	localparam int E_REP_FATAL5   = 6;
	localparam int E_DPAR_DMA_WR  = 7;
	localparam int E_DPAR_RD_RET  = 8;
	localparam int E_DPAR_OTHER   = 9;
	localparam int E_REP_UE_WR    = 10;
	localparam int E_ILL_CMD      = 11;
	localparam int E_UNSUP_CMD    = 12;
	localparam int E_NONEX_WR     = 13;
	localparam int E_NONEX_RD     = 14;
	localparam int E_TRANS_TO     = 15;
	localparam int E_UNMAP_WR     = 16;
	localparam int E_RD_ERR_CYC   = 17;
	localparam int E_UNEXP_DATA   = 18;
	localparam int E_IRQ_ACK_TO   = 19;

	// severity class and which errors capture the whole address group
	localparam logic [NUM_ERR-1:0] FATAL_MASK    = 20'h0001F;
	localparam logic [NUM_ERR-1:0] AD_GROUP_MASK = 20'h77F87;

	////////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] A_ERR_LOG   = 8'h00;
	localparam logic [7:0] A_OVF_LOG   = 8'h04;
	localparam logic [7:0] A_LOG_ENB   = 8'h08;
	localparam logic [7:0] A_SIG_ENB   = 8'h0C;
	localparam logic [7:0] A_LOG_ADDR  = 8'h10;
	localparam logic [7:0] A_LOG_DATA0 = 8'h14;
	localparam logic [7:0] A_LOG_DATA1 = 8'h18;
	localparam logic [7:0] A_LOG_CTRL  = 8'h1C;
	localparam logic [7:0] A_PARITY    = 8'h20;
	localparam logic [7:0] A_LOG_ARB   = 8'h24;
	localparam logic [7:0] A_LOG_NACK  = 8'h28;
	localparam logic [7:0] A_ARB_LIMIT = 8'h2C;
	localparam logic [7:0] A_STATUS    = 8'h30;

	// reset values
	localparam logic [NUM_ERR-1:0] LOG_ENB_RST = 20'hFFFFF;
	localparam logic [NUM_ERR-1:0] SIG_ENB_RST = 20'h00000;
	localparam logic [15:0]        ARB_LIMIT_RST = 16'hFFFF;

	////////////////////////////////////////////////////////////////////////////////
	// fatal indication protocol
	localparam int FATAL_BURST_LEN = 4;
	localparam int CTRL_PAR_DELAY  = 2;
	localparam int NUM_REP_PORTS   = 2;

endpackage : bei_pkg

/* File: core/bei_timeout_ctr.sv */
// arbitration timeout counter
`timescale 1ns/1ns
module bei_timeout_ctr #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// transaction status
	input  wire logic         pending,
	input  wire logic         issued,
	input  wire logic [W-1:0] limit,
	// result
	output logic              timeout
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	logic         next_timeout;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_count   = count;
		next_timeout = 1'b0;
		if (issued) begin
			next_count = '0;
		end else if (pending) begin
			if (count == limit) begin
				next_timeout = 1'b1;
				next_count   = '0;
			end else begin
				next_count = count + W'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count   <= '0;
			timeout <= 1'b0;
		end else begin
			count   <= next_count;
			timeout <= next_timeout;
		end
	end

endmodule : bei_timeout_ctr

/* File: core/bei_fatal_link.sv */
// fatal indication command: sends a burst, watches the other ports for one
`timescale 1ns/1ns
module bei_fatal_link (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               rst,
	// local request
	input  wire logic                               send,
	// fatal_indication_command seen from each reporting bus_port
	input  wire logic [bei_pkg::NUM_REP_PORTS-1:0]  port_cmd_seen,
	// outputs
	output logic                                    fatal_indication_command,
	output logic [bei_pkg::NUM_REP_PORTS-1:0]       port_fatal
);

	typedef enum logic [0:0] {BEI_IDLE, BEI_DRIVE} bei_burst_e;

	localparam logic [2:0] BURST_LAST = 3'(bei_pkg::FATAL_BURST_LEN - 1);
	localparam logic [2:0] SEEN_FULL  = 3'(bei_pkg::FATAL_BURST_LEN);

	bei_burst_e state;
	bei_burst_e next_state;
	logic [2:0] beat;
	logic [2:0] next_beat;
	logic       next_cmd;

	////////////////////////////////////////////////////////////////////////////////
	// four consecutive cycles of the command form the fatal_indication_burst
	always_comb begin
		next_state = state;
		next_beat  = beat;
		next_cmd   = 1'b0;
		unique case (state)
			BEI_IDLE: begin
				if (send) begin
					next_state = BEI_DRIVE;
					next_beat  = '0;
					next_cmd   = 1'b1;
				end
			end
			BEI_DRIVE: begin
				if (beat == BURST_LAST) begin
					next_state = BEI_IDLE;
				end else begin
					next_beat = beat + 3'h1;
					next_cmd  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state                    <= BEI_IDLE;
			beat                     <= '0;
			fatal_indication_command <= 1'b0;
		end else begin
			state                    <= next_state;
			beat                     <= next_beat;
			fatal_indication_command <= next_cmd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per port run-length detector; one pulse per burst
	genvar p;
	generate
		for (p = 0; p < bei_pkg::NUM_REP_PORTS; p++) begin : g_port
			logic [2:0] run;
			logic [2:0] next_run;
			logic       next_hit;
			always_comb begin
				next_run = '0;
				next_hit = 1'b0;
				if (port_cmd_seen[p]) begin
					next_run = (run == SEEN_FULL) ? run : run + 3'h1;
					next_hit = (run == BURST_LAST);
				end
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					run           <= '0;
					port_fatal[p] <= 1'b0;
				end else begin
					run           <= next_run;
					port_fatal[p] <= next_hit;
				end
			end
		end
	endgenerate

endmodule : bei_fatal_link

/* File: core/bei_error_handler.sv */
// bus interface error classification, logging and signalling
`timescale 1ns/1ns
module bei_error_handler #(
	parameter int ARB_W = 16
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// detector events, one-cycle pulses
	input  wire logic        addr_par_err,
	input  wire logic        upper_par_err_indet,
	input  wire logic        ill_adtype_err,
	input  wire logic        l2_flow_timeout,
	input  wire logic        dpar_dma_wr_err,
	input  wire logic        dpar_rd_ret_err,
	input  wire logic        dpar_other_err,
	input  wire logic        rep_ue_wr_err,
	input  wire logic        ill_cmd_err,
	input  wire logic        unsup_cmd_err,
	input  wire logic        nonex_wr_err,
	input  wire logic        nonex_rd_err,
	input  wire logic        trans_timeout,
	input  wire logic        unmap_wr_err,
	input  wire logic        rd_err_cycle,
	input  wire logic        unexp_data_err,
	input  wire logic        irq_ack_timeout,
	// bus observation
	input  wire logic [7:0]  bus_ctrl,
	input  wire logic        bus_ctrl_par,
	input  wire logic [31:0] bus_addr,
	input  wire logic [31:0] bus_data0,
	input  wire logic [31:0] bus_data1,
	input  wire logic [3:0]  address_data_parity,
	input  wire logic [1:0]  port_cmd_seen,
	// arbitration
	input  wire logic        txn_pending,
	input  wire logic        txn_issued,
	// indications
	output logic             poison_data,
	output logic             error_return,
	output logic             unmapped_err_cycle,
	output logic             async_intr,
	output logic             fatal_indication_command
);

	localparam int N = bei_pkg::NUM_ERR;

	logic [N-1:0]     error_log, next_error_log;
	logic [N-1:0]     overflow_error_log, next_overflow_error_log;
	logic [N-1:0]     log_enb, next_log_enb;
	logic [N-1:0]     sig_enb, next_sig_enb;
	logic [31:0]      log_addr, next_log_addr;
	logic [31:0]      log_data0, next_log_data0;
	logic [31:0]      log_data1, next_log_data1;
	logic [7:0]       log_ctrl, next_log_ctrl;
	logic [3:0]       parity_log, next_parity_log;
	logic [31:0]      log_arb, next_log_arb;
	logic [31:0]      log_nack, next_log_nack;
	logic [ARB_W-1:0] arb_limit, next_arb_limit;
	logic [31:0]      next_prdata;
	logic             next_pready, next_pslverr;
	logic             next_poison, next_err_ret, next_unmap, next_intr, send_fatal;

	logic [7:0]   ctrl_d1, ctrl_d2;
	logic [1:0]   par_vld;
	logic         ctrl_par_err;
	logic         arb_timeout;
	logic [1:0]   port_fatal;
	logic [N-1:0] raw, ev, fatal_ev, to_log, sig, clr_log, clr_ovf;
	logic         held_any, held_fatal, first, first_fatal;
	logic [4:0]   pick;
	logic         wr_acc;

	function automatic logic [4:0] lowest(input logic [N-1:0] v);
		logic [4:0] idx;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 5'(i);
			end
		end
		return idx;
	endfunction : lowest

	////////////////////////////////////////////////////////////////////////////////
	// helpers
	bei_timeout_ctr #(.W(ARB_W)) u_arb (
		.clk     (clk),
		.rst     (rst),
		.pending (txn_pending),
		.issued  (txn_issued),
		.limit   (arb_limit),
		.timeout (arb_timeout)
	);

	bei_fatal_link u_fatal (
		.clk                      (clk),
		.rst                      (rst),
		.send                     (send_fatal),
		.port_cmd_seen            (port_cmd_seen),
		.fatal_indication_command (fatal_indication_command),
		.port_fatal               (port_fatal)
	);

	// control parity pipeline; par_vld masks the check until two samples exist
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_d1 <= '0;
			ctrl_d2 <= '0;
			par_vld <= '0;
		end else begin
			ctrl_d1 <= bus_ctrl;
			ctrl_d2 <= ctrl_d1;
			par_vld <= {par_vld[0], 1'b1};
		end
	end

	assign ctrl_par_err = par_vld[1] && (bus_ctrl_par != ^ctrl_d2);

	////////////////////////////////////////////////////////////////////////////////
	// classification
	always_comb begin
		raw = '0;
		raw[bei_pkg::E_ADDR_PAR]    = addr_par_err | upper_par_err_indet;
		raw[bei_pkg::E_CTRL_PAR]    = ctrl_par_err;
		raw[bei_pkg::E_ILL_ADTYPE]  = ill_adtype_err;
		raw[bei_pkg::E_L2_FLOW_TO]  = l2_flow_timeout;
		raw[bei_pkg::E_ARB_TO]      = arb_timeout;
		raw[bei_pkg::E_REP_FATAL4]  = port_fatal[0];
		raw[bei_pkg::E_REP_FATAL5]  = port_fatal[1];
		raw[bei_pkg::E_DPAR_DMA_WR] = dpar_dma_wr_err;
		raw[bei_pkg::E_DPAR_RD_RET] = dpar_rd_ret_err;
		raw[bei_pkg::E_DPAR_OTHER]  = dpar_other_err;
		raw[bei_pkg::E_REP_UE_WR]   = rep_ue_wr_err;
		raw[bei_pkg::E_ILL_CMD]     = ill_cmd_err;
		raw[bei_pkg::E_UNSUP_CMD]   = unsup_cmd_err;
		raw[bei_pkg::E_NONEX_WR]    = nonex_wr_err;
		raw[bei_pkg::E_NONEX_RD]    = nonex_rd_err;
		raw[bei_pkg::E_TRANS_TO]    = trans_timeout;
		raw[bei_pkg::E_UNMAP_WR]    = unmap_wr_err;
		raw[bei_pkg::E_RD_ERR_CYC]  = rd_err_cycle;
		raw[bei_pkg::E_UNEXP_DATA]  = unexp_data_err;
		raw[bei_pkg::E_IRQ_ACK_TO]  = irq_ack_timeout;
	end

	assign ev         = raw & log_enb;
	assign fatal_ev   = ev & bei_pkg::FATAL_MASK;
	assign held_any   = |error_log;
	assign held_fatal = |(error_log & bei_pkg::FATAL_MASK);
	assign sig        = ev & sig_enb;
	assign wr_acc     = psel && penable && pready && pwrite;

	// a fatal error may still enter the log over an uncorrectable one
	always_comb begin
		first       = 1'b0;
		first_fatal = 1'b0;
		pick        = '0;
		to_log      = '0;
		if (!held_any && ev != '0) begin
			first  = 1'b1;
			pick   = (fatal_ev != '0) ? lowest(fatal_ev) : lowest(ev);
			to_log = N'(1) << pick;
		end else if (held_any && !held_fatal && fatal_ev != '0) begin
			first_fatal = 1'b1;
			pick        = lowest(fatal_ev);
			to_log      = N'(1) << pick;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// logs and detail capture; a set in the same cycle beats a software clear
	always_comb begin
		clr_log = (wr_acc && paddr == bei_pkg::A_ERR_LOG) ? pwdata[N-1:0] : '0;
		clr_ovf = (wr_acc && paddr == bei_pkg::A_OVF_LOG) ? pwdata[N-1:0] : '0;
		next_error_log          = (error_log & ~clr_log) | to_log;
		next_overflow_error_log = (overflow_error_log & ~clr_ovf) | (ev & ~to_log);
		next_log_addr   = log_addr;
		next_log_data0  = log_data0;
		next_log_data1  = log_data1;
		next_log_ctrl   = log_ctrl;
		next_parity_log = parity_log;
		next_log_arb    = log_arb;
		next_log_nack   = log_nack;
		if (first && bei_pkg::AD_GROUP_MASK[pick]) begin
			next_log_addr   = bus_addr;
			next_log_data0  = bus_data0;
			next_log_data1  = bus_data1;
			next_log_ctrl   = bus_ctrl;
			next_parity_log = address_data_parity;
		end
		if (first_fatal) begin
			unique case (pick)
				5'(bei_pkg::E_ADDR_PAR): begin
					next_log_data0 = bus_data0;
					next_log_data1 = bus_data1;
					next_log_ctrl  = bus_ctrl;
				end
				5'(bei_pkg::E_CTRL_PAR): begin
					next_parity_log = address_data_parity;
				end
				5'(bei_pkg::E_ILL_ADTYPE): begin
					next_log_ctrl = bus_ctrl;
				end
				default: begin
				end
			endcase
		end
		if ((first || first_fatal) && pick == 5'(bei_pkg::E_ARB_TO)) begin
			next_log_arb = bus_addr;
		end
		if (first && pick == 5'(bei_pkg::E_IRQ_ACK_TO)) begin
			next_log_nack = bus_addr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// indications
	always_comb begin
		next_poison  = ev[bei_pkg::E_DPAR_DMA_WR] | ev[bei_pkg::E_REP_UE_WR];
		next_err_ret = ev[bei_pkg::E_DPAR_RD_RET]
			| ev[bei_pkg::E_TRANS_TO]
			| ev[bei_pkg::E_RD_ERR_CYC];
		next_unmap   = ev[bei_pkg::E_NONEX_RD];
		next_intr    = |(sig & ~bei_pkg::FATAL_MASK);
		send_fatal   = |(sig & bei_pkg::FATAL_MASK);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			poison_data        <= 1'b0;
			error_return       <= 1'b0;
			unmapped_err_cycle <= 1'b0;
			async_intr         <= 1'b0;
		end else begin
			poison_data        <= next_poison;
			error_return       <= next_err_ret;
			unmapped_err_cycle <= next_unmap;
			async_intr         <= next_intr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb: one wait-free access phase, read data registered in the setup cycle
	always_comb begin
		next_pready    = psel && !penable && !pready;
		next_pslverr   = 1'b0;
		next_prdata    = prdata;
		next_log_enb   = log_enb;
		next_sig_enb   = sig_enb;
		next_arb_limit = arb_limit;
		if (psel && !penable) begin
			next_prdata = '0;
			unique case (paddr)
				bei_pkg::A_ERR_LOG:   next_prdata[N-1:0] = error_log;
				bei_pkg::A_OVF_LOG:   next_prdata[N-1:0] = overflow_error_log;
				bei_pkg::A_LOG_ENB:   next_prdata[N-1:0] = log_enb;
				bei_pkg::A_SIG_ENB:   next_prdata[N-1:0] = sig_enb;
				bei_pkg::A_LOG_ADDR:  next_prdata = log_addr;
				bei_pkg::A_LOG_DATA0: next_prdata = log_data0;
				bei_pkg::A_LOG_DATA1: next_prdata = log_data1;
				bei_pkg::A_LOG_CTRL:  next_prdata[7:0] = log_ctrl;
				bei_pkg::A_PARITY:    next_prdata[3:0] = parity_log;
				bei_pkg::A_LOG_ARB:   next_prdata = log_arb;
				bei_pkg::A_LOG_NACK:  next_prdata = log_nack;
				bei_pkg::A_ARB_LIMIT: next_prdata[ARB_W-1:0] = arb_limit;
				bei_pkg::A_STATUS:    next_prdata[2:0] =
					{fatal_indication_command, held_fatal, held_any};
				default:              next_pslverr = 1'b1;
			endcase
		end
		if (wr_acc) begin
			unique case (paddr)
				bei_pkg::A_LOG_ENB:   next_log_enb   = pwdata[N-1:0];
				bei_pkg::A_SIG_ENB:   next_sig_enb   = pwdata[N-1:0];
				bei_pkg::A_ARB_LIMIT: next_arb_limit = pwdata[ARB_W-1:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			error_log          <= '0;
			overflow_error_log <= '0;
			log_enb            <= bei_pkg::LOG_ENB_RST;
			sig_enb            <= bei_pkg::SIG_ENB_RST;
			log_addr           <= '0;
			log_data0          <= '0;
			log_data1          <= '0;
			log_ctrl           <= '0;
			parity_log         <= '0;
			log_arb            <= '0;
			log_nack           <= '0;
			arb_limit          <= ARB_W'(bei_pkg::ARB_LIMIT_RST);
			prdata             <= '0;
			pready             <= 1'b0;
			pslverr            <= 1'b0;
		end else begin
			error_log          <= next_error_log;
			overflow_error_log <= next_overflow_error_log;
			log_enb            <= next_log_enb;
			sig_enb            <= next_sig_enb;
			log_addr           <= next_log_addr;
			log_data0          <= next_log_data0;
			log_data1          <= next_log_data1;
			log_ctrl           <= next_log_ctrl;
			parity_log         <= next_parity_log;
			log_arb            <= next_log_arb;
			log_nack           <= next_log_nack;
			arb_limit          <= next_arb_limit;
			prdata             <= next_prdata;
			pready             <= next_pready;
			pslverr            <= next_pslverr;
		end
	end

endmodule : bei_error_handler

/* File: test/bei_monitor.sv */
// port checker for the bus interface error handler
`timescale 1ns/1ns
module bei_monitor (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// apb
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	// causes
	input wire logic       dpar_dma_wr_err,
	input wire logic       rep_ue_wr_err,
	input wire logic       dpar_rd_ret_err,
	input wire logic       trans_timeout,
	input wire logic       rd_err_cycle,
	input wire logic       nonex_rd_err,
	// indications
	input wire logic       poison_data,
	input wire logic       error_return,
	input wire logic       unmapped_err_cycle,
	input wire logic       fatal_indication_command
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////////////
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_burst;
		fatal_indication_command [*4];
	endsequence

	a_setup_answered: assert property (s_setup |=> pready)
		else $error("setup not answered next cycle");
	a_ready_cause: assert property (pready |-> $past(psel && !penable))
		else $error("ready without setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_slverr_qualified: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	a_burst_four: assert property ($rose(fatal_indication_command) |-> s_burst)
		else $error("fatal burst shorter than four");
	a_poison_cause: assert property (poison_data |-> $past(dpar_dma_wr_err | rep_ue_wr_err))
		else $error("poison without cause");
	a_errret_cause: assert property (error_return |->
		$past(dpar_rd_ret_err | trans_timeout | rd_err_cycle))
		else $error("error return without cause");
	a_unmap_cause: assert property (unmapped_err_cycle |-> $past(nonex_rd_err))
		else $error("unmapped cycle without cause");

endmodule : bei_monitor

bind bei_error_handler bei_monitor i_bei_monitor (
	.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
	.pslverr(pslverr), .dpar_dma_wr_err(dpar_dma_wr_err), .rep_ue_wr_err(rep_ue_wr_err),
	.dpar_rd_ret_err(dpar_rd_ret_err), .trans_timeout(trans_timeout),
	.rd_err_cycle(rd_err_cycle), .nonex_rd_err(nonex_rd_err), .poison_data(poison_data),
	.error_return(error_return), .unmapped_err_cycle(unmapped_err_cycle),
	.fatal_indication_command(fatal_indication_command)
);

/* File: test/bei_bus_agent.sv */
// model of the other agents on the shared bus
`timescale 1ns/1ns
module bei_bus_agent (
	// clock
	input wire logic    clk,
	// bus as seen by the block
	output logic [1:0]  port_cmd_seen,
	output logic [7:0]  bus_ctrl,
	output logic        bus_ctrl_par
);
	logic [7:0] hist;
	logic       bad;
	initial begin
		port_cmd_seen = 2'h0;
		bus_ctrl = 8'h00;
		bus_ctrl_par = 1'b0;
		hist = 8'h00;
		bad = 1'b0;
	end
	// controls move every cycle so a stale parity cannot keep matching by luck
	always @(posedge clk) begin
		bus_ctrl <= bus_ctrl + 8'h01;
		hist <= bus_ctrl;
		bus_ctrl_par <= (^hist) ^ bad;
	end
	task send_fatal(input int port, input int n);
		@(posedge clk) port_cmd_seen[port] <= 1'b1;
		repeat (n) @(posedge clk);
		port_cmd_seen[port] <= 1'b0;
	endtask : send_fatal
	task flip_parity();
		@(posedge clk) bad <= 1'b1;
		@(posedge clk) bad <= 1'b0;
	endtask : flip_parity
endmodule : bei_bus_agent

/* File: test/bus_interface_error_handler_tb.sv */
// self-checking bench for the bus interface error handler
`timescale 1ns/1ns
module bus_interface_error_handler_tb;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, bus_addr, bus_data0;
	logic [16:0] ev;
	logic        txn_pending, txn_issued, poison, eret, unm, intr, fci;
	wire  [1:0]  pcs;
	wire  [7:0]  ctrl;
	wire         cpar;
	int          num_errors, n_tests, n;
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ev, txn_pending, txn_issued, bus_data0} = '0;
		bus_addr = 32'h1234_5678;
		clk = 1'b0;
		rst = 1'b1;
		forever #20 clk = ~clk;
	end
	bei_bus_agent i_bei_bus_agent (.clk(clk), .port_cmd_seen(pcs), .bus_ctrl(ctrl),
		.bus_ctrl_par(cpar));
	bei_error_handler #(.ARB_W(16)) i_bei_error_handler (.clk(clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .addr_par_err(ev[0]),
		.upper_par_err_indet(ev[1]), .ill_adtype_err(ev[2]), .l2_flow_timeout(ev[3]),
		.dpar_dma_wr_err(ev[4]), .dpar_rd_ret_err(ev[5]), .dpar_other_err(ev[6]),
		.rep_ue_wr_err(ev[7]), .ill_cmd_err(ev[8]), .unsup_cmd_err(ev[9]),
		.nonex_wr_err(ev[10]), .nonex_rd_err(ev[11]), .trans_timeout(ev[12]),
		.unmap_wr_err(ev[13]), .rd_err_cycle(ev[14]), .unexp_data_err(ev[15]),
		.irq_ack_timeout(ev[16]), .bus_ctrl(ctrl), .bus_ctrl_par(cpar), .bus_addr(bus_addr),
		.bus_data0(bus_data0), .bus_data1(32'h0000_0000), .address_data_parity(4'h0),
		.port_cmd_seen(pcs), .txn_pending(txn_pending), .txn_issued(txn_issued),
		.poison_data(poison), .error_return(eret), .unmapped_err_cycle(unm),
		.async_intr(intr), .fatal_indication_command(fci));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk) penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a missing answer
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// one-cycle event, returns in the cycle where indications stand
	task fire(input int i);
		@(posedge clk) ev[i] <= 1'b1;
		@(posedge clk) ev <= '0;
		#1;
	endtask : fire
	task end_of_test();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		apb(0, bei_pkg::A_LOG_ENB, 0); chk("log_enb", rd, 32'h000F_FFFF);
		apb(0, bei_pkg::A_SIG_ENB, 0); chk("sig_enb", rd, 32'h0);
		apb(0, 8'h3C, 0); chk("unmapped", {err, rd[30:0]}, 32'h8000_0000);
		$display("test registers done");
		apb(1, bei_pkg::A_SIG_ENB, 32'h0000_00A1);
		fire(4); chk("poison", poison, 1);
		chk("intr", intr, 1);
		apb(0, bei_pkg::A_ERR_LOG, 0); chk("err_log", rd, 32'h80);
		apb(0, bei_pkg::A_LOG_ADDR, 0); chk("log_addr", rd, 32'h1234_5678);
		fire(11); chk("unmapped_cyc", unm, 1);
		chk("no_intr", intr, 0);
		apb(1, bei_pkg::A_LOG_ENB, 32'h000F_FEFF);
		fire(5); chk("masked_ret", eret, 0);
		apb(1, bei_pkg::A_LOG_ENB, 32'h000F_FFFF);
		fire(5); chk("err_ret", eret, 1);
		fire(12); chk("timeout_ret", eret, 1);
		apb(0, bei_pkg::A_OVF_LOG, 0); chk("ovf", rd, 32'hC100);
		$display("test uncorrectable done");
		// new detail so the first-fatal overwrite is visible
		bus_addr  <= 32'h0BAD_0ADD;
		bus_data0 <= 32'hA5A5_0F0F;
		fire(0);
		n = 0;
		repeat (6) begin if (fci === 1'b1) n++; @(posedge clk); #1; end
		chk("burst_len", n, 4);
		apb(0, bei_pkg::A_ERR_LOG, 0); chk("fatal_log", rd, 32'h81);
		apb(0, bei_pkg::A_LOG_DATA0, 0); chk("fatal_data0", rd, 32'hA5A5_0F0F);
		apb(0, bei_pkg::A_LOG_ADDR, 0); chk("kept_addr", rd, 32'h1234_5678);
		i_bei_bus_agent.send_fatal(0, 4);
		@(posedge clk) #1;
		chk("remote_intr", intr, 1);
		chk("remote_quiet", fci, 0);
		i_bei_bus_agent.send_fatal(1, 3);
		repeat (3) @(posedge clk);
		i_bei_bus_agent.flip_parity();
		repeat (3) @(posedge clk);
		apb(0, bei_pkg::A_OVF_LOG, 0); chk("ovf2", rd, 32'hC122);
		$display("test fatal done");
		apb(1, bei_pkg::A_OVF_LOG, 32'h000F_FFFF);
		apb(0, bei_pkg::A_OVF_LOG, 0); chk("ovf_clear", rd, 32'h0);
		apb(1, bei_pkg::A_ARB_LIMIT, 32'h3);
		@(posedge clk) txn_pending <= 1'b1;
		repeat (6) begin
			@(posedge clk) txn_issued <= 1'b1;
			@(posedge clk) txn_issued <= 1'b0;
		end
		apb(0, bei_pkg::A_OVF_LOG, 0); chk("arb_restart", rd, 32'h0);
		repeat (8) @(posedge clk);
		txn_pending <= 1'b0;
		apb(0, bei_pkg::A_OVF_LOG, 0); chk("arb_timeout", rd, 32'h10);
		$display("test arbitration done");
		end_of_test();
	end
endmodule : bus_interface_error_handler_tb
